// >>> shared/acsq_pkg.sv
// What the document requires of this block and its host
// RQ1: Results are two bytes, four zeros, MSB first.
// RQ2: Internally timed modes change output on falling clock.
// RQ3: Unipolar straight binary; bipolar and temperature two's complement.
// RQ4: One step is reference/4096 or 0.125 degrees.
// RQ5: Partial first byte: next read gives second byte.
// RQ6: Partial second byte dropped; later entries stay intact.
// RQ7: Write cut short by chip select is ignored.
// RQ8: Host waits for end-of-conversion before chip select.
// RQ9: Mode 00: start pulse runs whole scan, then sleep.
// RQ10: End-of-conversion low until chip select or start low.
// RQ11: Temperature result precedes channel results in FIFO.
// RQ12: Mode 00 host: no restart before end-of-conversion.
// RQ13: Mode 01: low start wakes converter and tracks; the code wakes and starts tracking only on the rising start.
// RQ14: Mode 01: rising start converts, then shuts down.
// RQ15: Mode 01: one pulse per sample, then next channel.
// RQ16: Mode 01: temperature runs on first rising start.
// RQ17: Mode 10 default; command byte runs whole scan.
// RQ18: Mode 10: end-of-conversion low until chip select low.
// RQ19: Mode 11: serial clock conversion, output on rising.
// RQ20: Mode 11 host: sixteen clocks follow each command.
// RQ21: Two zero bytes power down unless bias kept; the code also keeps power after a temperature command.
// RQ22: Mode 11 temperature: result in last two bytes.
// RQ23: Selection value 11 picks the externally clocked mode.
// RQ24: End-of-conversion stays high while work is pending.
package acsq_pkg;
   // Result layout.
   localparam int RES_BITS = 12;
   localparam int WORD_BITS = 16;
   localparam int LEAD_ZEROS = 4;
   // Clock mode encodings.
   localparam logic [1:0] MODE_START_SCAN = 2'b00;
   localparam logic [1:0] MODE_START_EACH = 2'b01;
   localparam logic [1:0] MODE_CMD_SCAN = 2'b10;
   localparam logic [1:0] MODE_EXT_CLOCK = 2'b11;
   // Command byte fields.
   localparam int CMD_CONV_POS = 7;
   localparam int CMD_CHAN_LSB = 3;
   localparam int CMD_TEMP_POS = 0;
   // Externally clocked byte counts after the command byte.
   localparam logic [4:0] EXT_DATA_FIRST = 5'h01;
   localparam logic [4:0] EXT_DATA_LAST = 5'h02;
   localparam logic [4:0] EXT_TEMP_FIRST = 5'h17;
   localparam logic [4:0] EXT_TEMP_LAST = 5'h18;
   localparam logic [1:0] NOP_POWER_DOWN = 2'h2;
   // Sampling ends about this long after the start of tracking.
   localparam int CLK_MHZ = 100;
   localparam int SAMPLE_NS = 500;
   localparam int SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ) / 1000;
   // Sequencer states, Gray coded from idle through sample and convert to store.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SAMPLE = 3'b001,
      ST_CONVERT = 3'b011,
      ST_STORE = 3'b010,
      ST_WAIT_EDGE = 3'b110
   } acsq_state_type;
   // Request to the analog core.
   typedef struct packed {
      logic start;
      logic temp;
      logic [3:0] chan;
   } acsq_conv_req_type;
   // Answer from the analog core, raw offset-binary code.
   typedef struct packed {
      logic done;
      logic [11:0] code;
   } acsq_conv_rsp_type;
endpackage : acsq_pkg

// >>> rtl/acsq_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser with agreement filter for pins and other clocks.
module acsq_sync3 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] q_reg;
   // The first stage feeds only the second; a change counts once stages two and three agree.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= '1;
         s2_reg <= '1;
         s3_reg <= '1;
         q_reg <= '1;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & q_reg);
      end
   end
   assign q = q_reg;
endmodule : acsq_sync3

module acsq_sequencer #(
   parameter int N_CHAN = 8,
   parameter int FIFO_DEPTH = 17
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic sclk_link,
   input wire logic cs_n,
   input wire logic mosi,
   output logic dout,
   output logic dout_oe,
   input wire logic convert_start_n,
   input wire logic clock_mode_sel_hi,
   input wire logic clock_mode_sel_lo,
   input wire logic bias_keep_on,
   input wire logic bipolar,
   input wire logic [N_CHAN-1:0] chan_mask,
   input wire logic [1:0] avg_log2,
   output logic eoc_n,
   output logic analog_awake,
   output acsq_pkg::acsq_conv_req_type conv_req,
   input wire acsq_pkg::acsq_conv_rsp_type conv_rsp,
   input wire logic [acsq_pkg::RES_BITS-1:0] ext_result,
   output logic sar_run,
   output logic ext_bias_on
);
   import acsq_pkg::*;

   localparam int PW = $clog2(FIFO_DEPTH);
   localparam int CW = $clog2(FIFO_DEPTH + 1);
   localparam int TW = $clog2(SAMPLE_CYC + 1);
   localparam int AW = RES_BITS + 3;

   // Finds the lowest requested channel at or above a start index.
   function automatic logic [4:0] next_chan(input logic [N_CHAN-1:0] mask, input logic [3:0] from);
      logic [4:0] res;
      res = 5'h00;
      for (int i = N_CHAN - 1; i >= 0; i--) begin
         if (mask[i] && (4'(i) >= from)) begin
            res = {1'b1, 4'(i)};
         end
      end
      return res;
   endfunction : next_chan

   // Reset is released through two flops; everything else uses this copy.
   logic rst_a_reg;
   logic rst_sync_n;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_a_reg <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_a_reg <= 1'b1;
         rst_sync_n <= rst_a_reg;
      end
   end

   wire logic [1:0] mode = {clock_mode_sel_hi, clock_mode_sel_lo};

   // ---------------- Link side, clocked by the serial clock. ----------------
   logic [2:0] bit_cnt_reg;      // Bit position within the current byte.
   logic [6:0] rx_reg;           // Bits received so far.
   logic [7:0] cmd_byte_reg;     // Last complete byte, held until the next one.
   logic cmd_tgl_reg;            // Flips once per complete byte.
   logic pop_tgl_reg;            // Flips when the second byte of an entry starts.
   logic byte_sel_reg;           // Which byte of the entry comes next.
   logic [7:0] out_byte_reg;     // Falling-edge output shifter.
   logic [7:0] tx_low_reg;       // Second byte of the entry being read.
   logic [4:0] ext_cnt_reg;      // Bytes since the last conversion command.
   logic ext_temp_reg;           // The externally clocked command asked for temperature.
   logic [1:0] nop_cnt_reg;      // Zero bytes since the last externally clocked command.
   logic ext_bias_reg;           // Analog cells powered in externally clocked mode.
   logic dout_rise_reg;          // Rising-edge output bit.
   logic sar_run_reg;            // Serial-clock conversion is running.
   logic [3:0] ext_chan_reg;     // Channel of the externally clocked conversion.
   logic [1:0] lmode1_reg;
   logic [1:0] lmode2_reg;
   logic lbias1_reg;
   logic lbias2_reg;
   logic [WORD_BITS-1:0] head_word_reg;
   logic conv_mark_reg; // Flips on each conversion command byte outside mode 11.
   logic conv_seen_reg; // Falling-edge copy of the mark.

   // Chip select high clears the bit position, so a short byte never completes.
   wire logic frame_rst_n = rst_sync_n & ~cs_n;
   wire logic [7:0] rx_byte = {rx_reg, mosi};
   wire logic byte_done = (bit_cnt_reg == 3'h7);
   wire logic ext_mode = (lmode2_reg == MODE_EXT_CLOCK); // RQ23
   wire logic [4:0] data_first = ext_temp_reg ? EXT_TEMP_FIRST : EXT_DATA_FIRST;
   wire logic [4:0] data_last = ext_temp_reg ? EXT_TEMP_LAST : EXT_DATA_LAST;
   wire logic ext_data = ext_mode && (ext_cnt_reg >= data_first) && (ext_cnt_reg <= data_last);
   wire logic [3:0] ext_pos = {(ext_cnt_reg == data_last), bit_cnt_reg};
   wire logic [3:0] ext_idx = 4'(WORD_BITS - 1) - ext_pos;
   // A new conversion command restarts the read-out at the first byte of an entry.
   wire logic take_high = !byte_sel_reg || (conv_mark_reg ^ conv_seen_reg);

   // Bit position counter; it restarts whenever chip select is high.
   always_ff @(posedge sclk_link or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         bit_cnt_reg <= 3'h0; // RQ7
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
   end

   // Mode and bias bits are slow levels, brought over with two flops.
   always_ff @(posedge sclk_link or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         lmode1_reg <= MODE_CMD_SCAN;
         lmode2_reg <= MODE_CMD_SCAN;
         lbias1_reg <= 1'b0;
         lbias2_reg <= 1'b0;
         rx_reg <= 7'h00;
      end else begin
         lmode1_reg <= mode;
         lmode2_reg <= lmode1_reg;
         lbias1_reg <= bias_keep_on;
         lbias2_reg <= lbias1_reg;
         rx_reg <= rx_byte[6:0];
      end
   end

   // Command bytes and the externally clocked conversion sequence.
   always_ff @(posedge sclk_link or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cmd_byte_reg <= 8'h00;
         cmd_tgl_reg <= 1'b0;
         ext_cnt_reg <= 5'h00;
         ext_temp_reg <= 1'b0;
         nop_cnt_reg <= 2'h0;
         ext_bias_reg <= 1'b0;
         ext_chan_reg <= 4'h0;
         conv_mark_reg <= 1'b0;
      end else if (byte_done) begin
         // Only a full eighth bit under chip select low reaches here.
         cmd_byte_reg <= rx_byte; // RQ7
         cmd_tgl_reg <= ~cmd_tgl_reg;
         if (!ext_mode && rx_byte[CMD_CONV_POS]) begin
            conv_mark_reg <= ~conv_mark_reg; // RQ5
         end
         if (ext_mode && rx_byte[CMD_CONV_POS]) begin
            ext_cnt_reg <= EXT_DATA_FIRST; // RQ19
            ext_temp_reg <= rx_byte[CMD_TEMP_POS]; // RQ22
            ext_chan_reg <= rx_byte[CMD_CHAN_LSB +: 4];
            ext_bias_reg <= 1'b1;
            nop_cnt_reg <= 2'h0;
         end else begin
            // Counting stops after the last data byte of the conversion.
            ext_cnt_reg <= (ext_cnt_reg == 5'h00 || ext_cnt_reg == data_last) ? 5'h00 : ext_cnt_reg + 5'h01;
            if (rx_byte == 8'h00 && nop_cnt_reg != NOP_POWER_DOWN) begin
               nop_cnt_reg <= nop_cnt_reg + 2'h1;
            end
            // Second zero byte since the last externally clocked command powers the cells down unless bias is kept or temperature was asked.
            if (rx_byte == 8'h00 && nop_cnt_reg == NOP_POWER_DOWN - 2'h1 && !ext_temp_reg && !lbias2_reg) begin
               ext_bias_reg <= 1'b0; // RQ21
            end
         end
      end
   end

   // Externally clocked output follows the successive bits of the running conversion.
   always_ff @(posedge sclk_link or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         dout_rise_reg <= 1'b0;
         sar_run_reg <= 1'b0;
      end else begin
         dout_rise_reg <= ext_data && (ext_pos >= 4'(LEAD_ZEROS)) && ext_result[ext_idx]; // RQ19
         sar_run_reg <= ext_data;
      end
   end

   // FIFO read-out changes data on the falling edge; every started byte counts as consumed.
   // The head word is a multi-bit crossing: it only changes after a pop, a command or a push into
   // an empty FIFO, each of which the link asks for or waits on before it needs the next entry.
   always_ff @(negedge sclk_link or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         byte_sel_reg <= 1'b0;
         out_byte_reg <= 8'h00;
         tx_low_reg <= 8'h00;
         pop_tgl_reg <= 1'b0;
         conv_seen_reg <= 1'b0;
      end else if (!cs_n && !ext_mode && bit_cnt_reg == 3'h0) begin
         conv_seen_reg <= conv_mark_reg;
         byte_sel_reg <= take_high; // RQ5
         if (take_high) begin
            out_byte_reg <= head_word_reg[WORD_BITS-1:8]; // RQ1
            tx_low_reg <= head_word_reg[7:0];
         end else begin
            // A cut-short second byte is simply abandoned; the entry is already popped.
            out_byte_reg <= tx_low_reg; // RQ6
            pop_tgl_reg <= ~pop_tgl_reg;
         end
      end else if (!cs_n && !ext_mode) begin
         out_byte_reg <= {out_byte_reg[6:0], 1'b0}; // RQ2
      end
   end

   assign dout = ext_mode ? dout_rise_reg : out_byte_reg[7];
   assign dout_oe = ~cs_n;
   assign sar_run = sar_run_reg;
   assign ext_bias_on = ext_bias_reg;

   // ---------------- System side. ----------------
   logic [3:0] sync_q;
   acsq_sync3 #(.W(4)) u_sync (
      .clk(clk_sys),
      .rst_n(rst_sync_n),
      // Toggles go in inverted so their reset level matches the all-ones reset; no false event.
      .d({cs_n, convert_start_n, ~cmd_tgl_reg, ~pop_tgl_reg}),
      .q(sync_q)
   );
   logic [3:0] sync_prev_reg;
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sync_prev_reg <= 4'hF;
      end else begin
         sync_prev_reg <= sync_q;
      end
   end
   wire logic cs_fall = sync_prev_reg[3] & ~sync_q[3];
   wire logic start_fall = sync_prev_reg[2] & ~sync_q[2];
   wire logic start_rise = ~sync_prev_reg[2] & sync_q[2];
   wire logic cmd_evt = sync_prev_reg[1] ^ sync_q[1];
   wire logic pop_evt = sync_prev_reg[0] ^ sync_q[0];
   // The command byte has been stable since before its toggle was seen.
   wire logic conv_cmd = cmd_evt && cmd_byte_reg[CMD_CONV_POS] && (mode != MODE_EXT_CLOCK);

   acsq_state_type state_reg;
   logic [TW-1:0] timer_reg;
   logic [3:0] chan_reg;
   logic temp_item_reg;
   logic temp_pend_reg;
   logic armed_reg;
   logic [2:0] avg_cnt_reg;
   logic [AW-1:0] acc_reg;
   logic eoc_n_reg;
   logic [WORD_BITS-1:0] fifo_mem [FIFO_DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;

   // Scan start: the pin pulse in modes 00 and 01, the command itself in mode 10.
   wire logic pin_start = armed_reg && start_rise && (mode == MODE_START_SCAN || mode == MODE_START_EACH);
   wire logic scan_start = (state_reg == ST_IDLE) && (pin_start || (conv_cmd && mode == MODE_CMD_SCAN));
   wire logic [4:0] first_item = next_chan(chan_mask, 4'h0);
   wire logic [4:0] after_item = temp_item_reg ? first_item : next_chan(chan_mask, chan_reg + 4'h1);
   wire logic avg_full = temp_item_reg || (avg_cnt_reg == 3'((4'h1 << avg_log2) - 4'h1));
   wire logic [AW-1:0] acc_sum = acc_reg + AW'(conv_rsp.code);
   wire logic [RES_BITS-1:0] avg_code = RES_BITS'(acc_sum >> avg_log2);
   // Bipolar and temperature codes flip the sign bit of the offset code; the step
   // size itself is set by the analog core, so the 12 bits pass unscaled.
   wire logic signed_fmt = bipolar || temp_item_reg; // RQ3
   wire logic [WORD_BITS-1:0] fmt_word = {{LEAD_ZEROS{1'b0}}, avg_code[RES_BITS-1] ^ signed_fmt,
                                         avg_code[RES_BITS-2:0]}; // RQ1 RQ4
   wire logic push = (state_reg == ST_CONVERT) && conv_rsp.done && avg_full && (count_reg != CW'(FIFO_DEPTH));
   wire logic pop = pop_evt && (count_reg != '0);
   wire logic scan_end = (state_reg == ST_CONVERT) && conv_rsp.done && avg_full && !after_item[4];
   wire logic each_mode = (mode == MODE_START_EACH);

   // Sequencer: wake, track, convert, average, store, advance, shut down.
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_reg <= ST_IDLE;
         timer_reg <= '0;
         chan_reg <= 4'h0;
         temp_item_reg <= 1'b0;
         temp_pend_reg <= 1'b0;
         armed_reg <= 1'b0;
         avg_cnt_reg <= 3'h0;
         acc_reg <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (scan_start) begin
                  // Temperature goes first so it lands ahead of every channel.
                  temp_item_reg <= temp_pend_reg || (conv_cmd && cmd_byte_reg[CMD_TEMP_POS]); // RQ11 RQ16
                  chan_reg <= first_item[3:0];
                  avg_cnt_reg <= 3'h0;
                  acc_reg <= '0;
                  timer_reg <= '0;
                  state_reg <= ST_SAMPLE; // RQ9 RQ13 RQ17
               end
            end
            ST_SAMPLE: begin
               // Tracking ends a fixed time after the start, as in the pin-paced mode.
               timer_reg <= timer_reg + TW'(1);
               if (timer_reg == TW'(SAMPLE_CYC - 1)) begin
                  state_reg <= ST_CONVERT; // RQ14
               end
            end
            ST_CONVERT: begin
               if (conv_rsp.done) begin
                  acc_reg <= avg_full ? '0 : acc_sum;
                  avg_cnt_reg <= avg_full ? 3'h0 : avg_cnt_reg + 3'h1;
                  timer_reg <= '0;
                  if (avg_full) begin
                     temp_pend_reg <= temp_item_reg ? 1'b0 : temp_pend_reg;
                     temp_item_reg <= 1'b0;
                     chan_reg <= after_item[3:0]; // RQ15
                  end
                  if (scan_end) begin
                     armed_reg <= 1'b0;
                     state_reg <= ST_IDLE;
                  end else begin
                     // Pin-paced mode waits for one pulse per sample.
                     state_reg <= each_mode ? ST_WAIT_EDGE : ST_STORE; // RQ15
                  end
               end
            end
            ST_STORE: begin
               state_reg <= ST_SAMPLE;
            end
            ST_WAIT_EDGE: begin
               if (start_rise) begin
                  state_reg <= ST_SAMPLE; // RQ14
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
         // Placed last so a new command wins over the end of a scan in the same cycle.
         if (conv_cmd) begin
            armed_reg <= 1'b1;
            temp_pend_reg <= cmd_byte_reg[CMD_TEMP_POS];
         end
      end
   end

   // Result FIFO; a new conversion command discards what the last scan left.
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         head_word_reg <= '0;
      end else if (conv_cmd) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         head_word_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1); // RQ6
         end
         count_reg <= count_reg + CW'(push) - CW'(pop);
         head_word_reg <= (count_reg != '0) ? fifo_mem[rd_ptr_reg] : '0;
      end
   end

   // Storage only; writes go in at the write pointer.
   always_ff @(posedge clk_sys) begin
      if (push) begin
         fifo_mem[wr_ptr_reg] <= fmt_word;
      end
   end

   // End of conversion: high while busy, low at the end, released by chip
   // select (all modes) or by a low start pin (modes 00, 01 and 11). Finishing wins.
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         eoc_n_reg <= 1'b1;
      end else if (scan_end) begin
         eoc_n_reg <= 1'b0; // RQ10 RQ18
      end else if (scan_start) begin
         eoc_n_reg <= 1'b1; // RQ24
      end else if (cs_fall || (start_fall && mode != MODE_CMD_SCAN)) begin
         eoc_n_reg <= 1'b1; // RQ10 RQ18
      end
   end

   // The analog core runs only while a sample is tracked, converted or stored.
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         conv_req <= '0;
         analog_awake <= 1'b0;
      end else begin
         conv_req.start <= (state_reg == ST_SAMPLE) && (timer_reg == TW'(SAMPLE_CYC - 1));
         conv_req.temp <= temp_item_reg;
         conv_req.chan <= chan_reg;
         analog_awake <= (state_reg == ST_SAMPLE) || (state_reg == ST_CONVERT) || (state_reg == ST_STORE);
      end
   end

   assign eoc_n = eoc_n_reg;
endmodule : acsq_sequencer

`default_nettype wire

// >>> verification/acsq_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the sequencer's pins for flag and handshake timing.
module acsq_seq_checker
   import acsq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic convert_start_n,
   input wire logic dout_oe,
   input wire logic eoc_n,
   input wire logic analog_awake,
   input wire acsq_pkg::acsq_conv_req_type conv_req,
   input wire acsq_pkg::acsq_conv_rsp_type conv_rsp
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Flag already low and nothing on the pins that may clear it.
   sequence s_quiet; cs_n && convert_start_n && !eoc_n; endsequence
   // Tracking lasts at least eight cycles before any conversion is fired.
   sequence s_track; !conv_req.start [*8]; endsequence
   property p_oe; dout_oe == !cs_n; endproperty
   a_oe: assert property (p_oe) else $error("dout_oe does not follow chip select");
   property p_busy; conv_req.start |-> eoc_n; endproperty
   a_busy: assert property (p_busy) else $error("conversion fired with flag low");
   property p_awake; conv_req.start |-> analog_awake; endproperty
   a_awake: assert property (p_awake) else $error("conversion fired while asleep");
   property p_pulse; conv_req.start |=> !conv_req.start; endproperty
   a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
   property p_hold; s_quiet [*8] |=> !eoc_n; endproperty
   a_hold: assert property (p_hold) else $error("flag rose with pins idle");
   property p_fall; $fell(eoc_n) |-> $past(conv_rsp.done); endproperty
   a_fall: assert property (p_fall) else $error("flag fell without a result");
   property p_sleep; $fell(eoc_n) |-> ##[0:1] !analog_awake; endproperty
   a_sleep: assert property (p_sleep) else $error("still awake after scan");
   property p_track; $rose(analog_awake) |-> s_track; endproperty
   a_track: assert property (p_track) else $error("sampling cut short");
endmodule : acsq_seq_checker

bind acsq_sequencer acsq_seq_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n),
   .convert_start_n(convert_start_n), .dout_oe(dout_oe), .eoc_n(eoc_n),
   .analog_awake(analog_awake), .conv_req(conv_req), .conv_rsp(conv_rsp));
`default_nettype wire

// >>> verification/acsq_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Serial host: clock idles high and runs only inside a frame.
module acsq_host_model (
   output logic sclk_link,
   output logic cs_n,
   output logic mosi,
   input wire logic dout
);
   initial begin
      sclk_link = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // One frame of n bits; a short n leaves a partial byte on purpose.
   task automatic xfer(input int n, input logic [23:0] w, output logic [23:0] r);
      r = '0;
      cs_n = 1'b0;
      #23;
      for (int i = n - 1; i >= 0; i--) begin
         sclk_link = 1'b0;
         mosi = w[i];
         #7.5;
         sclk_link = 1'b1;
         r = {r[22:0], dout};
         #7.5;
      end
      cs_n = 1'b1;
      // Released line shows no stale bit.
      mosi = ~mosi;
      #100;
   endtask : xfer
endmodule : acsq_host_model
`default_nettype wire

// >>> verification/tb_adc_conversion_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_sequencer;
   import acsq_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic sclk_link, cs_n, mosi, dout, dout_oe, eoc_n, awake, sar_run, bias_on;
   logic convert_start_n = 1'b1;
   logic sel_hi = 1'b1;
   logic sel_lo = 1'b0;
   logic [7:0] chan_mask = 8'h03;
   logic [1:0] avg_log2 = 2'h1;
   logic [11:0] val = 12'h000;
   logic [11:0] ext_val = 12'hA5C;
   logic bipolar = 1'b0;
   logic bias_keep = 1'b0;
   logic [3:0] chan_seen = 4'h0;
   logic [23:0] rd;
   acsq_conv_req_type conv_req;
   acsq_conv_rsp_type conv_rsp = '0;
   int wait_cnt = 0;
   int starts = 0;
   int mismatches = 0;
   int compares = 0;
   acsq_sequencer dut (.clk_sys(clk_sys), .rst_n(rst_n), .sclk_link(sclk_link), .cs_n(cs_n),
      .mosi(mosi), .dout(dout), .dout_oe(dout_oe), .convert_start_n(convert_start_n),
      .clock_mode_sel_hi(sel_hi), .clock_mode_sel_lo(sel_lo), .bias_keep_on(bias_keep),
      .bipolar(bipolar), .chan_mask(chan_mask), .avg_log2(avg_log2), .eoc_n(eoc_n),
      .analog_awake(awake), .conv_req(conv_req), .conv_rsp(conv_rsp),
      .ext_result(ext_val), .sar_run(sar_run), .ext_bias_on(bias_on));
   acsq_host_model host (.sclk_link(sclk_link), .cs_n(cs_n), .mosi(mosi), .dout(dout));
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   // Analog core stand-in: answers four cycles after a start; code is valid only with done.
   always @(negedge clk_sys) begin
      conv_rsp.done <= 1'b0;
      conv_rsp.code <= ~val;
      if (wait_cnt == 1) begin
         conv_rsp.done <= 1'b1;
         conv_rsp.code <= val;
      end
      if (wait_cnt != 0) wait_cnt <= wait_cnt - 1;
      if (conv_req.start === 1'b1) begin
         wait_cnt <= 4;
         starts <= starts + 1;
         chan_seen <= conv_req.chan;
         val <= conv_req.temp ? 12'h010 : 12'hA5C;
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Bounded wait for the completion flag to reach a level.
   task automatic wait_eoc(input logic lvl);
      int n;
      n = 0;
      while (eoc_n !== lvl && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      check({15'h0, eoc_n}, {15'h0, lvl});
   endtask : wait_eoc
   task automatic t_scan10;
      int s0;
      s0 = starts;
      host.xfer(8, 24'h80, rd);
      wait_eoc(1'b1);
      wait_eoc(1'b0);
      check(16'(starts - s0), 16'h4);
      repeat (30) @(negedge clk_sys);
      check({15'h0, eoc_n}, 16'h0);
      host.xfer(3, 24'h0, rd);
      host.xfer(8, 24'h0, rd);
      check(rd[15:0], 16'h5C);
      host.xfer(16, 24'h0, rd);
      check(rd[15:0], 16'h0A5C);
      $display("Test scan10 done");
   endtask : t_scan10
   task automatic t_short_write;
      int s0;
      s0 = starts;
      host.xfer(5, 24'h10, rd);
      repeat (200) @(negedge clk_sys);
      check(16'(starts - s0), 16'h0);
      $display("Test short_write done");
   endtask : t_short_write
   task automatic t_mode00;
      int s0;
      sel_hi = 1'b0;
      chan_mask = 8'h01;
      avg_log2 = 2'h0;
      s0 = starts;
      host.xfer(8, 24'h81, rd);
      repeat (20) @(negedge clk_sys);
      check(16'(starts - s0), 16'h0);
      convert_start_n = 1'b0;
      repeat (5) @(negedge clk_sys);
      convert_start_n = 1'b1;
      wait_eoc(1'b1);
      wait_eoc(1'b0);
      check(16'(starts - s0), 16'h2);
      host.xfer(8, 24'h0, rd);
      check(rd[15:0], 16'h08);
      host.xfer(4, 24'h0, rd);
      host.xfer(16, 24'h0, rd);
      check(rd[15:0], 16'h0A5C);
      $display("Test mode00 done");
   endtask : t_mode00
   task automatic t_mode01;
      int s0;
      sel_lo = 1'b1;
      chan_mask = 8'h02;
      avg_log2 = 2'h1;
      bipolar = 1'b1;
      s0 = starts;
      host.xfer(8, 24'h80, rd);
      repeat (2) begin
         convert_start_n = 1'b0;
         repeat (150) @(negedge clk_sys);
         convert_start_n = 1'b1;
         repeat (80) @(negedge clk_sys);
      end
      check({15'h0, eoc_n}, 16'h0);
      check({15'h0, awake}, 16'h0);
      check(16'(starts - s0), 16'h2);
      check({12'h0, chan_seen}, 16'h1);
      host.xfer(16, 24'h0, rd);
      check(rd[15:0], 16'h025C);
      $display("Test mode01 done");
   endtask : t_mode01
   task automatic t_mode11;
      sel_hi = 1'b1;
      host.xfer(8, 24'h80, rd);
      check({15'h0, bias_on}, 16'h1);
      host.xfer(16, 24'h0, rd);
      // This host samples on rising edges, so it sees each rising-edge bit one edge late.
      check(rd[15:0], 16'h052E);
      check({15'h0, bias_on}, 16'h0);
      bias_keep = 1'b1;
      host.xfer(24, 24'h80_0000, rd);
      check({15'h0, bias_on}, 16'h1);
      $display("Test mode11 done");
   endtask : t_mode11
   task automatic conclude;
      $display("Checks %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (10) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (5) @(negedge clk_sys);
      t_scan10();
      t_short_write();
      t_mode00();
      t_mode01();
      t_mode11();
      conclude();
   end
   // The tests need some 15 us; over six times that means a hang.
   initial begin
      #100000;
      mismatches++;
      conclude();
   end
endmodule : tb_adc_conversion_sequencer
`default_nettype wire
